/* rtl/smc_sleep_ctrl.sv */
`timescale 1ns/10ps
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int HALT_LEN = HALT_CYCLES,
  parameter int OSC_LEN = OSC_START_CYCLES
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Register bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic WB_SEL_I,
  output logic [7:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Core link
  input wire logic SLEEP_INSN,
  // Wake sources
  input wire logic EXT_LINE_A_LEVEL,
  input wire logic EXT_LINE_A_EDGE,
  input wire logic PIN_CHANGE_IRQ,
  input wire logic CONVERTER_IRQ,
  input wire logic OTHER_IO_IRQ,
  input wire logic WATCHDOG_IRQ,
  input wire logic SUPPLY_MONITOR_IRQ,
  // Peripheral status
  input wire logic CONVERTER_ENABLED,
  input wire logic COMPARATOR_OFF_BIT,
  // Clock domain enables
  output logic CORE_CLOCK_EN,
  output logic MEMORY_CLOCK_EN,
  output logic IO_CLOCK_EN,
  output logic CONVERTER_CLOCK_EN,
  output logic OSC_EN,
  output logic WATCHDOG_CLOCK_EN,
  // Peripheral clock and access
  output logic TIMER_CLOCK_EN,
  output logic TIMER_REG_ACCESS_EN,
  output logic CONVERTER_REG_ACCESS_EN,
  // Core and analog control
  output logic CORE_HALT,
  output logic IRQ_SERVICE_GO,
  output logic CONVERSION_START,
  output logic CONVERSION_EXTENDED,
  output logic COMPARATOR_FORCE_OFF,
  output logic INPUT_BUFFER_DISABLE,
  output logic SLEEPING
);
  // Whole module state
  typedef struct packed {
    // Control flow and counters
    smc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] mode;
    logic wake_seen;
    // Software visible registers
    logic allow;
    logic [2:0] sel;
    logic conv_gate;
    logic timer_gate;
    logic [7:0] rdata;
    // Registered outputs
    smc_clk_s clk;
    logic conv_clk;
    logic wdog_en;
    logic timer_en;
    logic timer_acc;
    logic conv_acc;
    logic halt;
    logic svc;
    logic conv_start;
    logic conv_ext;
    logic comp_off;
    logic ibuf_off;
    logic sleeping;
  } smc_state_s;

  // Counter load values, counted down to zero
  localparam logic [CNT_W-1:0] HALT_LOAD = CNT_W'(HALT_LEN - 1);
  localparam logic [CNT_W-1:0] OSC_LOAD = CNT_W'(OSC_LEN - 1);

  smc_state_s r;
  smc_state_s next_r;
  smc_wb_req_s req;
  smc_wake_s wake;
  smc_clk_s mode_clk;
  smc_clk_s run_clk;
  logic ack;
  logic wr_pulse;
  logic wake_hit;
  logic need_osc;
  logic legal;

  // Refuse settings the counters and fields cannot serve
  if (HALT_LEN < 1 || HALT_LEN > (1 << CNT_W)) begin : g_halt_chk
    $error("halt length does not fit the counter");
  end
  if (OSC_LEN < 1 || OSC_LEN > (1 << CNT_W)) begin : g_osc_chk
    $error("oscillator start length does not fit the counter");
  end
  if (SEL_LSB + 3 > 8 || ALLOW_BIT >= SEL_LSB) begin : g_field_chk
    $error("sleep control fields do not fit the register");
  end

  // Bus request bundle; a cleared byte select blocks the write
  assign req = '{
    cyc: WB_CYC_I,
    stb: WB_STB_I,
    we: WB_WE_I & WB_SEL_I,
    adr: WB_ADR_I,
    dat: WB_DAT_I
  };
  // Wake request bundle
  assign wake = '{
    ext_level: EXT_LINE_A_LEVEL,
    ext_edge: EXT_LINE_A_EDGE,
    pin_change: PIN_CHANGE_IRQ,
    converter: CONVERTER_IRQ,
    other_io: OTHER_IO_IRQ,
    watchdog: WATCHDOG_IRQ,
    supply_monitor: SUPPLY_MONITOR_IRQ
  };
  // Every domain running
  assign run_clk = '{
    core: 1'b1,
    memory: 1'b1,
    io: 1'b1,
    conv: 1'b1,
    osc: 1'b1
  };

  smc_wb_slave u_wb (
    .SYS_CLK(SYS_CLK),
    .RST_B(RST_B),
    .req(req),
    .ack(ack),
    .wr_pulse(wr_pulse)
  );

  // Decode of the mode latched at sleep entry
  smc_mode_decode u_dec (
    .sel(r.mode),
    .wake(wake),
    .clk_en(mode_clk),
    .wake_hit(wake_hit),
    .need_osc(need_osc),
    .legal(legal)
  );

  // Next state
  always_comb begin
    next_r = r;
    next_r.conv_start = 1'b0;
    next_r.svc = 1'b0;
    // Register writes land at the ack edge
    if (wr_pulse) begin
      if (req.adr == SLEEP_CONTROL_OFS) begin
        next_r.allow = req.dat[ALLOW_BIT];
        next_r.sel = req.dat[SEL_LSB +: 3];
      end else if (req.adr == PERIPH_GATE_OFS) begin
        next_r.conv_gate = req.dat[CONV_GATE_BIT];
        next_r.timer_gate = req.dat[TIMER_GATE_BIT];
      end
    end
    // Read data, unmapped reads zero
    next_r.rdata = 8'h00;
    if (req.cyc && req.stb && !req.we) begin
      if (req.adr == SLEEP_CONTROL_OFS) begin
        // Select field above the allow bit
        next_r.rdata = {4'h0, r.sel, r.allow};
      end else if (req.adr == PERIPH_GATE_OFS) begin
        // Two gate bits
        next_r.rdata = {6'h00, r.conv_gate, r.timer_gate};
      end else if (req.adr == WAKE_STATUS_OFS) begin
        // Wake seen, sleeping, latched mode
        next_r.rdata = {3'h0, r.wake_seen, r.st == ST_SLEEP, r.mode};
      end
    end
    // off then on gives extended conversion
    if (!CONVERTER_ENABLED) begin
      next_r.conv_ext = 1'b1;
    end else if (r.conv_start) begin
      next_r.conv_ext = 1'b0;
    end
    unique case (r.st)
      ST_RUN: begin
        // entry needs allow bit; otherwise no-operation
        if (SLEEP_INSN && r.allow && (r.sel inside {SEL_IDLE, SEL_NOISE, SEL_PDOWN,
            SEL_STBY})) begin
          next_r.st = ST_SLEEP;
          next_r.mode = r.sel;
          next_r.wake_seen = 1'b0;
          next_r.conv_start = CONVERTER_ENABLED && (r.sel == SEL_IDLE || r.sel == SEL_NOISE);
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          next_r.wake_seen = 1'b1;
          next_r.st = need_osc ? ST_OSC : ST_HALT;
          next_r.cnt = need_osc ? OSC_LOAD : HALT_LOAD;
        end
      end
      ST_OSC: begin
        if (r.cnt == '0) begin
          next_r.st = ST_HALT;
          next_r.cnt = HALT_LOAD;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      ST_HALT: begin
        if (r.cnt == '0) begin
          next_r.st = ST_RUN;
          next_r.svc = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
    endcase
    // Clock enables follow the state of the next cycle
    if (next_r.st == ST_SLEEP || next_r.st == ST_OSC) begin
      next_r.clk = mode_clk;
      if (next_r.st != r.st) begin
        next_r.clk = decode_clk(next_r.mode);
      end
      if (next_r.st == ST_OSC) begin
        next_r.clk = '0;
      end
    end else if (next_r.st == ST_HALT) begin
      next_r.clk = run_clk;
      next_r.clk.core = 1'b0;
    end else begin
      next_r.clk = run_clk;
    end
    // memory clock only stopped, contents kept
    // gated peripheral frozen; ungating resumes; active and idle
    next_r.timer_en = next_r.clk.io & ~next_r.timer_gate;
    next_r.timer_acc = ~next_r.timer_gate;
    next_r.conv_acc = ~next_r.conv_gate;
    // converter clock stays with converter in idle and noise reduction sleep
    next_r.conv_clk = next_r.clk.conv & ~next_r.conv_gate;
    next_r.wdog_en = 1'b1;
    next_r.halt = next_r.st != ST_RUN;
    next_r.sleeping = next_r.st == ST_SLEEP;
    next_r.comp_off = (next_r.st != ST_RUN) && (next_r.mode == SEL_PDOWN);
    // buffers off when io clock stops
    next_r.ibuf_off = ~next_r.clk.io;
  end

  // Clock map for a mode at entry
  function automatic smc_clk_s decode_clk(input logic [2:0] m);
    smc_clk_s c;
    c = '0;
    if (m == SEL_IDLE) begin
      c = '{core: 1'b0, memory: 1'b0, io: 1'b1, conv: 1'b1, osc: 1'b1};
    end else if (m == SEL_NOISE) begin
      c = '{core: 1'b0, memory: 1'b0, io: 1'b0, conv: 1'b1, osc: 1'b1};
    end else if (m == SEL_STBY) begin
      c.osc = 1'b1;
    end
    return c;
  endfunction : decode_clk

  // asynchronous reset returns to run from any state
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '{
        st: ST_RUN,
        cnt: '0,
        mode: SEL_IDLE,
        wake_seen: 1'b0,
        allow: SLEEP_CONTROL_RST[ALLOW_BIT],
        sel: SLEEP_CONTROL_RST[SEL_LSB +: 3],
        conv_gate: PERIPH_GATE_RST[CONV_GATE_BIT],
        timer_gate: PERIPH_GATE_RST[TIMER_GATE_BIT],
        rdata: 8'h00,
        clk: '{
          core: 1'b1,
          memory: 1'b1,
          io: 1'b1,
          conv: 1'b1,
          osc: 1'b1
        },
        conv_clk: 1'b1,
        wdog_en: 1'b1,
        timer_en: 1'b1,
        timer_acc: 1'b1,
        conv_acc: 1'b1,
        halt: 1'b0,
        svc: 1'b0,
        conv_start: 1'b0,
        conv_ext: 1'b1,
        comp_off: 1'b0,
        ibuf_off: 1'b0,
        sleeping: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  // Bus answer, both from flip-flops
  assign WB_DAT_O = r.rdata;
  assign WB_ACK_O = ack;
  // Clock domain enables straight from state
  assign CORE_CLOCK_EN = r.clk.core;
  assign MEMORY_CLOCK_EN = r.clk.memory;
  assign IO_CLOCK_EN = r.clk.io;
  assign CONVERTER_CLOCK_EN = r.conv_clk;
  assign OSC_EN = r.clk.osc;
  assign WATCHDOG_CLOCK_EN = r.wdog_en;
  // Peripheral clock and register access
  assign TIMER_CLOCK_EN = r.timer_en;
  assign TIMER_REG_ACCESS_EN = r.timer_acc;
  assign CONVERTER_REG_ACCESS_EN = r.conv_acc;
  // Core handshake and analog control
  assign CORE_HALT = r.halt;
  assign IRQ_SERVICE_GO = r.svc;
  assign CONVERSION_START = r.conv_start;
  assign CONVERSION_EXTENDED = r.conv_ext;
  assign COMPARATOR_FORCE_OFF = r.comp_off;
  assign INPUT_BUFFER_DISABLE = r.ibuf_off;
  assign SLEEPING = r.sleeping;
endmodule : smc_sleep_ctrl

/* rtl/smc_pkg.sv */
package smc_pkg;
  localparam logic [7:0] SLEEP_CONTROL_OFS = 8'h3a;
  localparam logic [7:0] PERIPH_GATE_OFS = 8'h35;
  localparam logic [7:0] WAKE_STATUS_OFS = 8'h3b;
  localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_GATE_RST = 8'h00;
  localparam int ALLOW_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int CONV_GATE_BIT = 1;
  localparam int TIMER_GATE_BIT = 0;
  localparam logic [2:0] SEL_IDLE = 3'h0;
  localparam logic [2:0] SEL_NOISE = 3'h1;
  localparam logic [2:0] SEL_PDOWN = 3'h2;
  localparam logic [2:0] SEL_STBY = 3'h4;
  localparam int HALT_CYCLES = 4;
  localparam int OSC_START_CYCLES = 6;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] HALT_CNT = CNT_W'(HALT_CYCLES);
  localparam logic [CNT_W-1:0] OSC_CNT = CNT_W'(OSC_START_CYCLES);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_OSC,
    ST_HALT
  } smc_state_e;

  // Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
  } smc_wb_req_s;

  // Wake-up sources
  typedef struct packed {
    logic ext_level;
    logic ext_edge;
    logic pin_change;
    logic converter;
    logic other_io;
    logic watchdog;
    logic supply_monitor;
  } smc_wake_s;

  // Clock domain enables
  typedef struct packed {
    logic core;
    logic memory;
    logic io;
    logic conv;
    logic osc;
  } smc_clk_s;
endpackage : smc_pkg

/* rtl/smc_mode_decode.sv */
`timescale 1ns/10ps
module smc_mode_decode
  import smc_pkg::*;
(
  input wire logic [2:0] sel,
  input wire smc_wake_s wake,
  output smc_clk_s clk_en,
  output logic wake_hit,
  output logic need_osc,
  output logic legal
);
  // Mode to clock map and wake filter
  always_comb begin
    clk_en = '0;
    wake_hit = 1'b0;
    need_osc = 1'b0;
    legal = 1'b1;
    unique case (sel)
      SEL_IDLE: begin
        clk_en = '{core: 1'b0, memory: 1'b0, io: 1'b1, conv: 1'b1, osc: 1'b1};
        wake_hit = |wake;
      end
      SEL_NOISE: begin
        clk_en = '{core: 1'b0, memory: 1'b0, io: 1'b0, conv: 1'b1, osc: 1'b1};
        wake_hit = wake.ext_level | wake.pin_change | wake.converter | wake.watchdog
          | wake.supply_monitor;
      end
      SEL_PDOWN: begin
        wake_hit = wake.ext_level | wake.pin_change | wake.watchdog;
        need_osc = 1'b1;
      end
      SEL_STBY: begin
        clk_en.osc = 1'b1;
        wake_hit = wake.ext_level | wake.pin_change | wake.watchdog;
      end
      default: legal = 1'b0;
    endcase
  end
endmodule : smc_mode_decode

/* rtl/smc_wb_slave.sv */
`timescale 1ns/10ps
module smc_wb_slave
  import smc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire smc_wb_req_s req,
  output logic ack,
  output logic wr_pulse
);
  typedef struct packed {
    logic ack;
  } smc_wbs_s;
  smc_wbs_s r;
  smc_wbs_s next_r;

  // One wait cycle then ack; drops the cycle after
  always_comb begin
    next_r.ack = req.cyc & req.stb & ~r.ack;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ack = r.ack;
  assign wr_pulse = r.ack & req.we;
endmodule : smc_wb_slave

/* tb/smc_core_model.sv */
`timescale 1ns/10ps
module smc_core_model
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sleep_req,
  input wire smc_wake_s raise,
  input wire logic service_go,
  output logic sleep_insn,
  output smc_wake_s irq
);
  // sleep instruction pulse
  // Requests stay pending until the core services them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_insn <= 1'b0;
      irq <= '0;
    end else begin
      sleep_insn <= sleep_req;
      irq <= service_go ? '0 : (irq | raise);
    end
  end
endmodule : smc_core_model

/* tb/smc_sleep_ctrl_monitor.sv */
`timescale 1ns/10ps
module smc_sleep_ctrl_monitor
  import smc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic SLEEP_INSN,
  input wire logic CONVERTER_ENABLED,
  input wire logic CORE_CLOCK_EN,
  input wire logic MEMORY_CLOCK_EN,
  input wire logic CONVERTER_CLOCK_EN,
  input wire logic OSC_EN,
  input wire logic WATCHDOG_CLOCK_EN,
  input wire logic CORE_HALT,
  input wire logic IRQ_SERVICE_GO,
  input wire logic CONVERSION_START,
  input wire logic COMPARATOR_FORCE_OFF,
  input wire logic SLEEPING
);
  logic [CNT_W-1:0] hcnt;
  logic [CNT_W-1:0] ocnt;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // Halt and oscillator start cycles since wake
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hcnt <= '0;
      ocnt <= '0;
    end else begin
      hcnt <= (CORE_HALT && !SLEEPING && OSC_EN) ? hcnt + 1'b1 : '0;
      ocnt <= (CORE_HALT && !SLEEPING && !OSC_EN) ? ocnt + 1'b1 : '0;
    end
  end
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_idle; SLEEPING |-> !CORE_CLOCK_EN && !MEMORY_CLOCK_EN; endproperty
  a_idle: assert property (p_idle) else $error("core clock runs");
  property p_noop; !SLEEPING && !CORE_HALT && !SLEEP_INSN |=> !SLEEPING; endproperty
  a_noop: assert property (p_noop) else $error("sleep without insn");
  property p_halt; IRQ_SERVICE_GO |-> hcnt == HALT_CNT; endproperty
  a_halt: assert property (p_halt) else $error("halt length");
  property p_osc; $rose(OSC_EN) |-> ocnt == OSC_CNT; endproperty
  a_osc: assert property (p_osc) else $error("osc start length");
  property p_wdog; !CORE_CLOCK_EN |-> WATCHDOG_CLOCK_EN; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog stopped");
  property p_cmp; SLEEPING && !OSC_EN |-> COMPARATOR_FORCE_OFF; endproperty
  a_cmp: assert property (p_cmp) else $error("comparator on");
  property p_conv;
    $rose(SLEEPING) && CONVERTER_ENABLED && CONVERTER_CLOCK_EN |-> CONVERSION_START;
  endproperty
  a_conv: assert property (p_conv) else $error("no conversion");
  c_sleep: cover property ($rose(SLEEPING));
  c_go: cover property (IRQ_SERVICE_GO);
  c_osc: cover property ($rose(OSC_EN) && CORE_HALT);
endmodule : smc_sleep_ctrl_monitor

bind smc_sleep_ctrl smc_sleep_ctrl_monitor u_mon (.*);

/* tb/smc_sleep_ctrl_tb_top.sv */
`timescale 1ns/10ps
module smc_sleep_ctrl_tb_top
  import smc_pkg::*;
;
  logic SYS_CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I, SLEEP_INSN, sleep_req;
  logic [7:0] WB_ADR_I, WB_DAT_I, WB_DAT_O, q;
  logic WB_ACK_O, EXT_LINE_A_LEVEL, EXT_LINE_A_EDGE, PIN_CHANGE_IRQ, CONVERTER_IRQ;
  logic OTHER_IO_IRQ, WATCHDOG_IRQ, SUPPLY_MONITOR_IRQ, CONVERTER_ENABLED, COMPARATOR_OFF_BIT;
  logic CORE_CLOCK_EN, MEMORY_CLOCK_EN, IO_CLOCK_EN, CONVERTER_CLOCK_EN, OSC_EN;
  logic WATCHDOG_CLOCK_EN, TIMER_CLOCK_EN, TIMER_REG_ACCESS_EN, CONVERTER_REG_ACCESS_EN;
  logic CORE_HALT, IRQ_SERVICE_GO, CONVERSION_START, CONVERSION_EXTENDED;
  logic COMPARATOR_FORCE_OFF, INPUT_BUFFER_DISABLE, SLEEPING;
  logic [7:0] gv [3] = '{8'h01, 8'h02, 8'h00};
  logic [7:0] nv [4] = '{8'h00, 8'h07, 8'h0b, 8'h0f};
  smc_wake_s raise, irq;
  int miscompares, n_compared;
  // Wake requests from the core model
  assign {EXT_LINE_A_LEVEL, EXT_LINE_A_EDGE, PIN_CHANGE_IRQ, CONVERTER_IRQ, OTHER_IO_IRQ,
    WATCHDOG_IRQ, SUPPLY_MONITOR_IRQ} = irq;
  smc_sleep_ctrl dut (.*);
  smc_core_model u_core (.clk(SYS_CLK), .rst_b(RST_B), .sleep_req(sleep_req),
    .raise(raise), .service_go(IRQ_SERVICE_GO), .sleep_insn(SLEEP_INSN), .irq(irq));
  // 10 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task wrap_up;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // Classic single bus cycle, read data lands in q
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge SYS_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    if (WB_ACK_O !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask : wb
  task insn;
    @(posedge SYS_CLK) sleep_req <= 1'b1;
    @(posedge SYS_CLK) sleep_req <= 1'b0;
    repeat (2) @(negedge SYS_CLK);
  endtask : insn
  task raise_src(input smc_wake_s s);
    @(posedge SYS_CLK) raise <= s;
    @(posedge SYS_CLK) raise <= '0;
  endtask : raise_src
  // Sleep in one mode, try a source that must not wake, then one that must
  task nap(input logic [2:0] sel, input smc_wake_s bad, input smc_wake_s good);
    int n;
    logic [4:0] e;
    e = (sel == SEL_IDLE) ? 5'h07 : (sel == SEL_NOISE) ? 5'h03 : (sel == SEL_STBY) ? 5'h01 : 5'h00;
    wb(1'b1, SLEEP_CONTROL_OFS, {4'h0, sel, 1'b1});
    insn();
    chk(SLEEPING, 1'b1);
    chk({CORE_CLOCK_EN, MEMORY_CLOCK_EN, IO_CLOCK_EN, CONVERTER_CLOCK_EN, OSC_EN}, e);
    chk(CONVERSION_START, sel <= SEL_NOISE);
    chk(COMPARATOR_FORCE_OFF, sel == SEL_PDOWN);
    chk({INPUT_BUFFER_DISABLE, WATCHDOG_CLOCK_EN}, {!e[2], 1'b1});
    raise_src(bad);
    repeat (8) @(negedge SYS_CLK);
    chk(SLEEPING, 1'b1);
    raise_src(good);
    n = 0;
    for (int i = 0; i < 40 && IRQ_SERVICE_GO !== 1'b1; i++) begin
      @(negedge SYS_CLK);
      if (!SLEEPING && CORE_HALT) n++;
    end
    if (IRQ_SERVICE_GO !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    chk(n, HALT_CYCLES + ((sel == SEL_PDOWN) ? OSC_START_CYCLES : 0));
    wb(1'b1, SLEEP_CONTROL_OFS, 8'h00);
    $display("test sleep mode %0d done", sel);
  endtask : nap
  task t_regs;
    wb(1'b0, SLEEP_CONTROL_OFS, 8'h00);
    chk(q, SLEEP_CONTROL_RST);
    wb(1'b1, 8'h10, 8'h5a);
    wb(1'b0, 8'h10, 8'h00);
    chk(q, 8'h00);
    foreach (gv[i]) begin
      wb(1'b1, PERIPH_GATE_OFS, gv[i]);
      wb(1'b0, PERIPH_GATE_OFS, 8'h00);
      chk(q, gv[i]);
      chk({TIMER_CLOCK_EN, TIMER_REG_ACCESS_EN}, {2{!gv[i][0]}});
      chk(CONVERTER_REG_ACCESS_EN, !gv[i][1]);
    end
    WB_SEL_I <= 1'b0;
    wb(1'b1, PERIPH_GATE_OFS, 8'h03);
    WB_SEL_I <= 1'b1;
    wb(1'b0, PERIPH_GATE_OFS, 8'h00);
    chk(q, 8'h00);
    foreach (nv[i]) begin
      wb(1'b1, SLEEP_CONTROL_OFS, nv[i]);
      insn();
      chk({SLEEPING, CORE_CLOCK_EN}, 2'b01);
    end
    $display("test registers done");
  endtask : t_regs
  initial begin
    {RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, sleep_req} = '0;
    {WB_SEL_I, CONVERTER_ENABLED, COMPARATOR_OFF_BIT} = 3'b110;
    raise = '0;
    miscompares = 0;
    n_compared = 0;
    repeat (6) @(posedge SYS_CLK);
    chk(CONVERSION_EXTENDED, 1'b1);
    RST_B <= 1'b1;
    t_regs();
    for (int b = 0; b < 7; b++) nap(SEL_IDLE, 7'h00, 7'(1 << b));
    chk(CONVERSION_EXTENDED, 1'b0);
    CONVERTER_ENABLED <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk(CONVERSION_EXTENDED, 1'b1);
    CONVERTER_ENABLED <= 1'b1;
    nap(SEL_NOISE, 7'h20, 7'h40);
    nap(SEL_NOISE, 7'h04, 7'h08);
    nap(SEL_PDOWN, 7'h08, 7'h10);
    nap(SEL_STBY, 7'h01, 7'h02);
    wb(1'b1, SLEEP_CONTROL_OFS, {4'h0, SEL_PDOWN, 1'b1});
    insn();
    chk(SLEEPING, 1'b1);
    @(posedge SYS_CLK) RST_B <= 1'b0;
    @(posedge SYS_CLK) RST_B <= 1'b1;
    @(negedge SYS_CLK);
    chk({SLEEPING, CORE_CLOCK_EN, OSC_EN}, 3'h3);
    $display("test reset in sleep done");
    wrap_up();
  end
endmodule : smc_sleep_ctrl_tb_top
